// ### hw/tcc_cfg.svh
// Constants for the 16-bit capture/compare timer: offsets, fields, resets.
// Assumes a plain one-cycle register port with read data one cycle later.
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define TCC_OFS_MODE     3'h0
`define TCC_OFS_CCCTL    3'h1
`define TCC_OFS_OUTCTL   3'h2
`define TCC_OFS_PRESC    3'h3
`define TCC_OFS_COUNT    3'h4
`define TCC_OFS_CCA      3'h5
`define TCC_OFS_CCB      3'h6
`define TCC_OFS_STATUS   3'h7

// ****************************************
// Field positions
// ****************************************
`define TCC_MODE_OVF_BIT     0
`define TCC_MODE_TOGEDGE_BIT 1
`define TCC_MODE_LO_BIT      2
`define TCC_MODE_HI_BIT      3
`define TCC_CC_A_CAP_BIT     0
`define TCC_CC_A_SELB_BIT    1
`define TCC_CC_B_CAP_BIT     2
`define TCC_OUT_EN_BIT       0
`define TCC_OUT_LVL_BIT      1
`define TCC_ES_A_LO_BIT      4
`define TCC_ES_B_LO_BIT      6

// ****************************************
// Reset values and fixed counts
// ****************************************
`define TCC_RST_BYTE   8'h00
`define TCC_RST_WORD   16'h0000
`define TCC_CNT_MAX    16'hffff
`define TCC_PRESC_DIV  8'h01

`endif

// ### hw/tcc_pkg.sv
// Types for the 16-bit capture/compare timer.
// Assumes tcc_cfg.svh is compiled alongside.
package tcc_pkg;

   // Operating modes held in the two-bit mode field
   typedef enum logic [1:0] {
      TCC_STOP  = 2'b00,
      TCC_FREE  = 2'b01,
      TCC_EDGE  = 2'b10,
      TCC_PULSE = 2'b11
   } tcc_mode_e;

   // Valid-edge selections for the capture pins
   typedef enum logic [1:0] {
      TCC_ES_FALL = 2'b00,
      TCC_ES_RISE = 2'b01,
      TCC_ES_NONE = 2'b10,
      TCC_ES_BOTH = 2'b11
   } tcc_edge_e;

endpackage

// ### hw/tcc_timer.sv
// 16-bit up-counting timer with two capture/compare registers and pulse
// generation. Assumes capture pins are already synchronous to sys_clk.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`include "tcc_cfg.svh"

// Function
// - Mode 01 runs free, counter increments each count clock.
// - After FFFFH set overflow flag, wrap to 0000H, keep counting.
// - Register A compare match raises first interrupt, counter runs on.
// - Register B compare match raises second interrupt, counter runs on.
// - Register A captures on selected pin A or pin B valid edge.
// - Register B captures only on pin A valid edge.
// - Timer output unavailable while pin B edge detection is used.
// - Both comparing: toggle output and interrupt on either match.
// - Compare/capture: register A match interrupts and toggles output.
// - Compare/capture: pin A edge interrupts and loads register B.
// - Both capturing: no toggle unless edge bit set, then pin A edges.
// - Both capturing: pin A loads register B, pin B loads A.
// - Both capturing with only pin B edges never loads B.
// - Reading the counter register returns the current count.
// - Mode 11 clears counter on register A match, pulse output.
// - Pulse period equals register A plus one count clocks.
// - Duty equals register B plus one over register A plus one.
// - Mode 10 restarts counter on pin A valid edge.
// - In mode 10 counter clears right after capturing on edge.
// - Pulse mode register A match interrupts and clears counter.
module tcc_timer
   import tcc_pkg::*;
#(
   parameter int CW = 16
)(
   input  wire logic          sys_clk,
   input  wire logic          resetn,
   input  wire logic [2:0]    regAddr,
   input  wire logic [7:0]    regWdataLo,
   input  wire logic [15:0]   regWdata,
   input  wire logic          regWr,
   input  wire logic          regRd,
   output logic      [15:0]   regRdata,
   input  wire logic          capturePinA,
   input  wire logic          capturePinB,
   output logic               timerOutputPin,
   output logic               timerOutputEn,
   output logic               irqRegA,
   output logic               irqRegB
);

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0]    modeCtl_q;
   logic [7:0]    ccCtl_q;
   logic [7:0]    outCtl_q;
   logic [7:0]    presc_q;
   logic [CW-1:0] upCounter_q;
   logic [CW-1:0] ccRegA_q;
   logic [CW-1:0] ccRegB_q;
   logic [7:0]    prDiv_q;
   logic          pinA_q;
   logic          pinB_q;
   logic          outLvl_q;

   tcc_mode_e     mode;
   tcc_edge_e     esA;
   tcc_edge_e     esB;
   logic          tick;
   logic          aCap;
   logic          aSelB;
   logic          bCap;
   logic          edgeA;
   logic          edgeB;
   logic          matchA;
   logic          matchB;
   logic          capA;
   logic          capB;
   logic          clrCnt;
   logic          wrMode;
   logic          ovfSet;
   logic          toggle;

   function automatic logic edge_hit(input tcc_edge_e es,
                                     input logic prev,
                                     input logic cur);
      case (es)
         TCC_ES_FALL: edge_hit = prev & ~cur;
         TCC_ES_RISE: edge_hit = ~prev & cur;
         TCC_ES_BOTH: edge_hit = prev ^ cur;
         default:     edge_hit = 1'b0;
      endcase
   endfunction

   assign mode  = tcc_mode_e'(modeCtl_q[`TCC_MODE_HI_BIT:`TCC_MODE_LO_BIT]);
   assign esA   = tcc_edge_e'(presc_q[`TCC_ES_A_LO_BIT +: 2]);
   assign esB   = tcc_edge_e'(presc_q[`TCC_ES_B_LO_BIT +: 2]);
   assign aCap  = ccCtl_q[`TCC_CC_A_CAP_BIT];
   assign aSelB = ccCtl_q[`TCC_CC_A_SELB_BIT];
   assign bCap  = ccCtl_q[`TCC_CC_B_CAP_BIT];
   assign wrMode = regWr && (regAddr == `TCC_OFS_MODE);

   // ****************************************
   // Count clock and edge detection
   // ****************************************
   // Prescaler gives a one-cycle count enable; divide is presc low nibble+1
   always_ff @(posedge sys_clk) begin
      if (!resetn || mode == TCC_STOP || prDiv_q >= {4'h0, presc_q[3:0]})
         prDiv_q <= 8'h00;
      else
         prDiv_q <= prDiv_q + `TCC_PRESC_DIV;
   end
   assign tick = (mode != TCC_STOP) && (prDiv_q >= {4'h0, presc_q[3:0]});

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pinA_q <= 1'b0;
         pinB_q <= 1'b0;
      end else begin
         pinA_q <= capturePinA;
         pinB_q <= capturePinB;
      end
   end
   assign edgeA = edge_hit(esA, pinA_q, capturePinA);
   assign edgeB = edge_hit(esB, pinB_q, capturePinB);

   // Compare matches are evaluated once per count tick
   assign matchA = tick && !aCap && (upCounter_q == ccRegA_q);
   assign matchB = tick && !bCap && (upCounter_q == ccRegB_q);

   assign capA = aCap && (aSelB ? edgeB : edgeA);
   // Register B only sees pin A
   assign capB = bCap && edgeA;

   assign clrCnt = (mode == TCC_PULSE && matchA) ||
                   (mode == TCC_EDGE && edgeA);

   // ****************************************
   // Counter and overflow
   // ****************************************
   // Count, wrap, edge restart
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         upCounter_q <= `TCC_RST_WORD;
      else if (mode == TCC_STOP)
         upCounter_q <= `TCC_RST_WORD;
      else if (clrCnt)
         upCounter_q <= `TCC_RST_WORD;
      else if (tick)
         upCounter_q <= upCounter_q + 16'h0001;
   end

   assign ovfSet = tick && !clrCnt && (upCounter_q == `TCC_CNT_MAX);

   // Sticky overflow: set beats a software clear
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         modeCtl_q <= `TCC_RST_BYTE;
      else if (wrMode)
         modeCtl_q <= {regWdataLo[7:1], regWdataLo[0] | ovfSet};
      else if (ovfSet)
         modeCtl_q[`TCC_MODE_OVF_BIT] <= 1'b1;
   end

   // ****************************************
   // Capture/compare registers
   // ****************************************
   // Register A capture beats a software write
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         ccRegA_q <= `TCC_RST_WORD;
      else if (capA)
         ccRegA_q <= upCounter_q;
      else if (regWr && regAddr == `TCC_OFS_CCA)
         ccRegA_q <= regWdata;
   end

   // Register B capture on pin A
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         ccRegB_q <= `TCC_RST_WORD;
      else if (capB)
         ccRegB_q <= upCounter_q;
      else if (regWr && regAddr == `TCC_OFS_CCB)
         ccRegB_q <= regWdata;
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ccCtl_q  <= `TCC_RST_BYTE;
         outCtl_q <= `TCC_RST_BYTE;
         presc_q  <= `TCC_RST_BYTE;
      end else if (regWr) begin
         if (regAddr == `TCC_OFS_CCCTL)
            ccCtl_q <= regWdataLo;
         if (regAddr == `TCC_OFS_OUTCTL)
            outCtl_q <= regWdataLo;
         if (regAddr == `TCC_OFS_PRESC)
            presc_q <= regWdataLo;
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************
   // One-cycle interrupt pulses
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         irqRegA <= 1'b0;
         irqRegB <= 1'b0;
      end else begin
         irqRegA <= matchA || (aCap && edgeB);
         irqRegB <= matchB || capB;
      end
   end

   // ****************************************
   // Timer output
   // ****************************************
   // Toggle sources; both-capture uses pin A only
   assign toggle = matchA || matchB ||
                   (modeCtl_q[`TCC_MODE_TOGEDGE_BIT] && edgeA);

   // Pulse: high from restart until B match
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         outLvl_q <= 1'b0;
      else if (mode == TCC_PULSE) begin
         if (matchA)
            outLvl_q <= 1'b1;
         else if (matchB)
            outLvl_q <= 1'b0;
      end else if (wrMode && regWdataLo[3:2] == 2'b11)
         outLvl_q <= 1'b1;
      else if (toggle)
         outLvl_q <= ~outLvl_q;
   end

   // Pin B edge use takes the output pin away
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         timerOutputPin <= 1'b0;
         timerOutputEn  <= 1'b0;
      end else begin
         timerOutputPin <= outLvl_q;
         timerOutputEn  <= outCtl_q[`TCC_OUT_EN_BIT] &&
                           !(aCap && aSelB && esB != TCC_ES_NONE);
      end
   end

   // ****************************************
   // Register read port
   // ****************************************
   // Counter reads live value
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         regRdata <= `TCC_RST_WORD;
      else if (regRd) begin
         case (regAddr)
            `TCC_OFS_MODE:   regRdata <= {8'h00, modeCtl_q};
            `TCC_OFS_CCCTL:  regRdata <= {8'h00, ccCtl_q};
            `TCC_OFS_OUTCTL: regRdata <= {8'h00, outCtl_q};
            `TCC_OFS_PRESC:  regRdata <= {8'h00, presc_q};
            `TCC_OFS_COUNT:  regRdata <= upCounter_q;
            `TCC_OFS_CCA:    regRdata <= ccRegA_q;
            `TCC_OFS_CCB:    regRdata <= ccRegB_q;
            `TCC_OFS_STATUS: regRdata <= {14'h0000, outLvl_q, tick};
            default:         regRdata <= `TCC_RST_WORD;
         endcase
      end else
         regRdata <= `TCC_RST_WORD;
   end

   // ****************************************
   // Checks
   // ****************************************
   a_wrap_to_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
      ovfSet |=> upCounter_q == 16'h0000)
      else $error("counter did not wrap");
   a_ovf_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
      ovfSet |=> modeCtl_q[0])
      else $error("overflow flag not set");
   a_ovf_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      modeCtl_q[0] && !wrMode |=> modeCtl_q[0])
      else $error("overflow flag dropped by hardware");
   a_count_step: assert property (@(posedge sys_clk) disable iff (!resetn)
      tick && mode == TCC_FREE && !clrCnt && !ovfSet
      |=> upCounter_q == $past(upCounter_q) + 16'h0001)
      else $error("counter did not step");
   a_irqa_match: assert property (@(posedge sys_clk) disable iff (!resetn)
      matchA |=> irqRegA)
      else $error("missing irq A");
   a_irqb_match: assert property (@(posedge sys_clk) disable iff (!resetn)
      matchB |=> irqRegB)
      else $error("missing irq B");
   a_capb_value: assert property (@(posedge sys_clk) disable iff (!resetn)
      capB |=> ccRegB_q == $past(upCounter_q) && irqRegB)
      else $error("register B capture wrong");
   a_capa_value: assert property (@(posedge sys_clk) disable iff (!resetn)
      capA |=> ccRegA_q == $past(upCounter_q))
      else $error("register A capture wrong");
   a_edge_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
      mode == TCC_EDGE && edgeA |=> upCounter_q == 16'h0000)
      else $error("edge restart missed");
   a_pulse_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
      mode == TCC_PULSE && matchA |=> upCounter_q == 16'h0000 && outLvl_q)
      else $error("pulse restart wrong");
   a_pulse_width: assert property (@(posedge sys_clk) disable iff (!resetn)
      mode == TCC_PULSE && matchB && !matchA |=> !outLvl_q)
      else $error("pulse did not end on B match");
   a_out_blocked: assert property (@(posedge sys_clk) disable iff (!resetn)
      aCap && aSelB && esB != TCC_ES_NONE |=> !timerOutputEn)
      else $error("output enabled with pin B edges");

   c_overflow:  cover property (@(posedge sys_clk) ovfSet);
   c_cap_b:     cover property (@(posedge sys_clk) capB);
   c_pulse:     cover property (@(posedge sys_clk)
      mode == TCC_PULSE && matchA);
   c_edge_clr:  cover property (@(posedge sys_clk)
      mode == TCC_EDGE && edgeA);

endmodule

// ### dv/tcc_pulse_src.sv
// Behavioural source of pulses on the two capture pins.
// Assumes the timer samples both pins on rising sys_clk edges.
`timescale 1ns/100ps
module tcc_pulse_src (
   input  wire logic sys_clk,
   output logic      capturePinA,
   output logic      capturePinB
);
   initial begin
      capturePinA = 1'b0;
      capturePinB = 1'b0;
   end
   // Pins are driven levels, so they hold low between pulses
   task automatic pulse(input bit onB, input int hi);
      @(posedge sys_clk);
      if (onB) capturePinB <= 1'b1;
      else capturePinA <= 1'b1;
      repeat (hi) @(posedge sys_clk);
      if (onB) capturePinB <= 1'b0;
      else capturePinA <= 1'b0;
   endtask
endmodule

// ### dv/tb_tcc_timer.sv
// Self-checking bench for the capture/compare timer.
// Assumes a prescaler divide of one, so the counter ticks every cycle.
`timescale 1ns/100ps
`include "tcc_cfg.svh"
module tb_tcc_timer;
   import tcc_pkg::*;
   logic        sys_clk = 1'b0, resetn = 1'b0;
   logic [2:0]  regAddr = 3'h0;
   logic [7:0]  regWdataLo = 8'h00;
   logic [15:0] regWdata = 16'h0000, regRdata, lastRd, v, w;
   logic        regWr = 1'b0, regRd = 1'b0, rdPend = 1'b0;
   logic        capturePinA, capturePinB, timerOutputPin, timerOutputEn;
   logic        irqRegA, irqRegB;
   logic [16:0] expQ[$], e;
   int          num_errors = 0, samples_checked = 0, cyc = 0, seed = 57;
   int          aCnt = 0, bCnt = 0, aCyc = 0, bCyc = 0, k, t0, t1, t2;
   localparam logic [16:0] DC = 17'h10000;

   tcc_timer u_tcc_timer (.sys_clk(sys_clk), .resetn(resetn),
      .regAddr(regAddr), .regWdataLo(regWdataLo), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .capturePinA(capturePinA), .capturePinB(capturePinB),
      .timerOutputPin(timerOutputPin), .timerOutputEn(timerOutputEn),
      .irqRegA(irqRegA), .irqRegB(irqRegB));
   tcc_pulse_src u_tcc_pulse_src (.sys_clk(sys_clk),
      .capturePinA(capturePinA), .capturePinB(capturePinB));

   always #20 sys_clk = ~sys_clk;

   task final_report;
      $display("errors %0d, checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // ****************************************
   // Output watcher: read data, interrupts, timeout
   // ****************************************
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 90000) begin
         num_errors++;
         final_report;
      end
      if (irqRegA === 1'b1) begin aCnt++; aCyc = cyc; end
      if (irqRegB === 1'b1) begin bCnt++; bCyc = cyc; end
      if (rdPend) begin
         e = expQ.pop_front();
         lastRd = regRdata;
         if (!e[16]) chk(regRdata, e[15:0]);
      end
      rdPend = regRd;
   end
   // ****************************************
   // Bus tasks
   // ****************************************
   task wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdataLo <= d[7:0];
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   task rd(input logic [2:0] a, input logic [16:0] x);
      @(posedge sys_clk);
      expQ.push_back(x);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   // Baseline is taken by the caller: a pulse may raise the irq before return
   task waitIrq(input bit onB, input int c0);
      repeat (40) begin
         @(posedge sys_clk);
         #1;
         if ((onB ? bCnt : aCnt) != c0) break;
      end
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 8; i++) rd(3'(i), (i == 7) ? DC : 17'h0);
      // Free running, both registers comparing, no pin edges
      wr(`TCC_OFS_CCA, 16'h0010);
      wr(`TCC_OFS_CCB, 16'h0020);
      wr(`TCC_OFS_OUTCTL, 16'h0001);
      wr(`TCC_OFS_PRESC, 16'h00a0);
      wr(`TCC_OFS_MODE, 16'h0004);
      rd(`TCC_OFS_COUNT, DC);
      v = lastRd;
      rd(`TCC_OFS_COUNT, {1'b0, v + 16'h0003});
      waitIrq(1'b0, aCnt);
      repeat (3) @(posedge sys_clk);
      chk({15'h0, timerOutputPin}, 16'h0001);
      waitIrq(1'b1, bCnt);
      chk(16'(bCyc - aCyc), 16'h0010);
      repeat (3) @(posedge sys_clk);
      chk({15'h0, timerOutputPin}, 16'h0000);
      // Let the counter run past its top value
      rd(`TCC_OFS_COUNT, DC);
      k = 65536 - int'(lastRd) + 8;
      repeat (k) @(posedge sys_clk);
      rd(`TCC_OFS_MODE, 17'h00005);
      rd(`TCC_OFS_COUNT, DC);
      chk(16'(lastRd < 16'h0020), 16'h0001);
      // Software clears the sticky flag itself
      wr(`TCC_OFS_MODE, 16'h0004);
      rd(`TCC_OFS_MODE, 17'h00004);
      // Compare on A, capture on B from pin A rising
      wr(`TCC_OFS_PRESC, 16'h0090);
      wr(`TCC_OFS_CCCTL, 16'h0004);
      k = bCnt;
      u_tcc_pulse_src.pulse(1'b0, 2);
      waitIrq(1'b1, k);
      chk(16'(bCnt - k), 16'h0001);
      rd(`TCC_OFS_COUNT, DC);
      v = lastRd;
      rd(`TCC_OFS_CCB, DC);
      chk(16'(v - lastRd < 16'h000c), 16'h0001);
      // Both capturing; A takes pin B, B takes pin A
      wr(`TCC_OFS_PRESC, 16'h0050);
      wr(`TCC_OFS_CCCTL, 16'h0007);
      repeat (2) @(posedge sys_clk);
      #1;
      chk({15'h0, timerOutputEn}, 16'h0000);
      rd(`TCC_OFS_CCB, DC);
      w = lastRd;
      k = aCnt;
      u_tcc_pulse_src.pulse(1'b1, 3);
      waitIrq(1'b0, k);
      chk(16'(aCnt - k), 16'h0001);
      rd(`TCC_OFS_CCB, {1'b0, w});
      k = bCnt;
      u_tcc_pulse_src.pulse(1'b0, 1);
      waitIrq(1'b1, k);
      chk(16'(bCnt - k), 16'h0001);
      // Clear and restart the running counter on pin A rising edge
      wr(`TCC_OFS_CCCTL, 16'h0004);
      wr(`TCC_OFS_PRESC, 16'h0090);
      wr(`TCC_OFS_MODE, 16'h0008);
      repeat (30) @(posedge sys_clk);
      k = bCnt;
      u_tcc_pulse_src.pulse(1'b0, 2);
      waitIrq(1'b1, k);
      rd(`TCC_OFS_COUNT, DC);
      chk(16'(lastRd < 16'h000a), 16'h0001);
      rd(`TCC_OFS_CCB, DC);
      chk(16'(lastRd > 16'h0014), 16'h0001);
      // Pulse generation with random period and width, width below period
      v = 16'h0004 + (16'($random(seed)) & 16'h0007);
      w = 16'($unsigned($random(seed)) % v);
      wr(`TCC_OFS_CCCTL, 16'h0000);
      wr(`TCC_OFS_CCA, v);
      wr(`TCC_OFS_CCB, w);
      // Stop first so the counter starts below the short period
      wr(`TCC_OFS_MODE, 16'h0000);
      wr(`TCC_OFS_MODE, 16'h000c);
      @(posedge timerOutputPin);
      #1 t0 = cyc;
      @(negedge timerOutputPin);
      #1 t1 = cyc;
      @(posedge timerOutputPin);
      #1 t2 = cyc;
      chk(16'(t1 - t0), w + 16'h0001);
      chk(16'(t2 - t0), v + 16'h0001);
      waitIrq(1'b0, aCnt);
      k = aCyc;
      waitIrq(1'b0, aCnt);
      chk(16'(aCyc - k), v + 16'h0001);
      final_report;
   end
endmodule
